// [hpa_pkg.sv]
package hpa_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int SYNC_W = 27;

  // ------------------------------------------------------------
  // indirect port locations and mode control layout
  // ------------------------------------------------------------
  localparam logic [1:0] LOC_MODE = 2'h0;
  localparam logic [1:0] LOC_PTR_HI = 2'h1;
  localparam logic [1:0] LOC_PTR_LO = 2'h2;
  localparam logic [1:0] LOC_DATA = 2'h3;
  localparam logic [14:0] DIRECT_MODE_ADDR = 15'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_IND_BIT = 0;
  localparam int MODE_AI_BIT = 1;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ------------------------------------------------------------
  // serial frame
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WRITE = 8'hF0;
  localparam logic [7:0] OP_READ = 8'h0F;
  localparam logic [5:0] FRAME_LAST = 6'h1F;
  localparam logic [5:0] HDR_LAST = 6'h17;
  localparam logic [5:0] DATA_FIRST = 6'h18;
  localparam logic [5:0] FRAME_BITS = 6'h20;

  // ------------------------------------------------------------
  // synchronised pin vector layout
  // ------------------------------------------------------------
  localparam int PIN_SCLK = 14;
  localparam int PIN_SS = 13;
  localparam int PIN_MOSI = 12;
  localparam int S_DATA = 15;
  localparam int S_CS = 23;
  localparam int S_RD = 24;
  localparam int S_WR = 25;
  localparam int S_SPIEN = 26;

  typedef enum logic [1:0] {
    HPA_DIRECT = 2'b00,
    HPA_INDIRECT = 2'b01,
    HPA_SERIAL = 2'b10
  } hpa_port_t;

endpackage

// [hpa_sync.sv]
`timescale 1ns/1ns
// three-stage pin synchroniser; output moves once stages two and three agree
module hpa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  // ------------------------------------------------------------
  // agreement filter, per bit
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
    end
  end

  // stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_ff <= INIT;
    end else if (ce) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

// [hpa_host_port.sv]
`timescale 1ns/1ns
module hpa_host_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [hpa_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [hpa_pkg::DATA_W-1:0] data_in,
  output logic [hpa_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic int_n,
  input wire logic spi_en,
  output logic miso_out,
  output logic miso_oe,
  input wire logic int_req,
  output logic [hpa_pkg::ADDR_W-1:0] mem_addr,
  output logic [hpa_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [hpa_pkg::DATA_W-1:0] mem_rdata
);
  import hpa_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_INIT = {1'b0, 3'h7, 8'h00, 15'h0000};
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] prev_ff, nxt_prev;

  // strobes idle high, serial enable low, so reset fakes no edge or mode
  hpa_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .d({spi_en, wr_n, rd_n, cs_n, data_in, addr_pin}),
    .q(pins)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] mode_ff, nxt_mode;
  logic [15:0] ptr_ff, nxt_ptr;
  logic [7:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe;
  logic int_n_ff, nxt_int_n;
  logic miso_ff, nxt_miso;
  logic miso_oe_ff, nxt_miso_oe;
  logic [14:0] maddr_ff, nxt_maddr;
  logic [7:0] mwdata_ff, nxt_mwdata;
  logic mwe_ff, nxt_mwe;
  logic mre_ff, nxt_mre;
  logic rd_pend_ff, nxt_rd_pend;
  logic spi_pend_ff, nxt_spi_pend;
  logic [31:0] sh_ff, nxt_sh;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [7:0] mso_ff, nxt_mso;
  logic spi_rd_ff, nxt_spi_rd;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic is_edge_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic is_edge_rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  hpa_port_t port;
  logic [1:0] loc;
  logic rd_start, rd_end, wr_end, sclk_rise, sclk_fall, ss_n;
  logic [31:0] shifted;

  // ------------------------------------------------------------
  // port selection and strobe edges
  // ------------------------------------------------------------
  always_comb begin
    if (pins[S_SPIEN]) begin
      port = HPA_SERIAL;
    end else if (mode_ff[MODE_IND_BIT]) begin
      port = HPA_INDIRECT;
    end else begin
      port = HPA_DIRECT;
    end
  end

  assign loc = pins[1:0];
  assign rd_start = is_edge_fall(prev_ff[S_RD], pins[S_RD]) & ~pins[S_CS];
  assign rd_end = is_edge_rise(prev_ff[S_RD], pins[S_RD]);
  // write taken at the trailing edge, while chip select was still low
  assign wr_end = is_edge_rise(prev_ff[S_WR], pins[S_WR]) & ~prev_ff[S_CS];
  assign sclk_rise = is_edge_rise(prev_ff[PIN_SCLK], pins[PIN_SCLK]);
  assign sclk_fall = is_edge_fall(prev_ff[PIN_SCLK], pins[PIN_SCLK]);
  assign ss_n = pins[PIN_SS];
  // msb first into the low end
  assign shifted = {sh_ff[30:0], pins[PIN_MOSI]};

  // ------------------------------------------------------------
  // next-state logic for the whole port
  // ------------------------------------------------------------
  always_comb begin
    nxt_prev = pins;
    nxt_mode = mode_ff;
    nxt_ptr = ptr_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_int_n = ~int_req;
    nxt_miso = miso_ff;
    nxt_miso_oe = miso_oe_ff;
    nxt_maddr = maddr_ff;
    nxt_mwdata = mwdata_ff;
    nxt_mwe = 1'b0;
    nxt_mre = 1'b0;
    nxt_rd_pend = 1'b0;
    nxt_spi_pend = 1'b0;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_mso = mso_ff;
    nxt_spi_rd = spi_rd_ff;

    // memory answer lands one cycle after the read pulse
    if (rd_pend_ff) begin
      nxt_dout = mem_rdata;
    end
    if (spi_pend_ff) begin
      nxt_mso = mem_rdata;
    end

    if (port != HPA_SERIAL) begin
      // parallel bus; serial side held idle
      nxt_cnt = 6'd0;
      nxt_spi_rd = 1'b0;
      nxt_miso_oe = 1'b0;
      if (pins[S_CS]) begin
        nxt_doe = 1'b0;
      end
      if (rd_start) begin
        nxt_doe = 1'b1;
        if (port == HPA_DIRECT) begin
          if (pins[14:0] == DIRECT_MODE_ADDR) begin
            nxt_dout = mode_ff;
          end else begin
            nxt_maddr = pins[14:0];
            nxt_mre = 1'b1;
            nxt_rd_pend = 1'b1;
          end
        end else begin
          case (loc)
            LOC_MODE: nxt_dout = mode_ff;
            LOC_PTR_HI: nxt_dout = ptr_ff[15:8];
            LOC_PTR_LO: nxt_dout = ptr_ff[7:0];
            LOC_DATA: begin
              nxt_maddr = ptr_ff[14:0];
              nxt_mre = 1'b1;
              nxt_rd_pend = 1'b1;
            end
            default: nxt_dout = 8'h00;
          endcase
        end
      end
      if (rd_end) begin
        nxt_doe = 1'b0;
        if (port == HPA_INDIRECT && loc == LOC_DATA && mode_ff[MODE_AI_BIT]) begin
          nxt_ptr = ptr_ff + PTR_STEP;
        end
      end
      if (wr_end) begin
        if (port == HPA_DIRECT) begin
          if (pins[14:0] == DIRECT_MODE_ADDR) begin
            nxt_mode = pins[S_DATA +: 8];
          end else begin
            nxt_maddr = pins[14:0];
            nxt_mwdata = pins[S_DATA +: 8];
            nxt_mwe = 1'b1;
          end
        end else begin
          case (loc)
            LOC_MODE: nxt_mode = pins[S_DATA +: 8];
            LOC_PTR_HI: nxt_ptr = {pins[S_DATA +: 8], ptr_ff[7:0]};
            LOC_PTR_LO: nxt_ptr = {ptr_ff[15:8], pins[S_DATA +: 8]};
            LOC_DATA: begin
              // window goes to the loaded pointer
              nxt_maddr = ptr_ff[14:0];
              nxt_mwdata = pins[S_DATA +: 8];
              nxt_mwe = 1'b1;
              if (mode_ff[MODE_AI_BIT]) begin
                nxt_ptr = ptr_ff + PTR_STEP;
              end
            end
            default: nxt_mode = mode_ff;
          endcase
        end
      end
    end else begin
      nxt_doe = 1'b0;
      if (ss_n) begin
        nxt_cnt = 6'd0;
        nxt_spi_rd = 1'b0;
        nxt_miso_oe = 1'b0;
      end else begin
        if (sclk_rise && cnt_ff != FRAME_BITS) begin
          nxt_sh = shifted;
          nxt_cnt = cnt_ff + 6'd1;
          // read fetched once header is in
          if (cnt_ff == HDR_LAST && shifted[23:16] == OP_READ) begin
            nxt_maddr = shifted[14:0];
            nxt_mre = 1'b1;
            nxt_spi_pend = 1'b1;
            nxt_spi_rd = 1'b1;
            nxt_miso_oe = 1'b1;
          end
          // write commits on the 32nd bit
          if (cnt_ff == FRAME_LAST && shifted[31:24] == OP_WRITE) begin
            nxt_maddr = shifted[22:8];
            nxt_mwdata = shifted[7:0];
            nxt_mwe = 1'b1;
          end
        end
        if (sclk_fall && spi_rd_ff && cnt_ff >= DATA_FIRST && cnt_ff != FRAME_BITS) begin
          nxt_miso = mso_ff[7];
          nxt_mso = {mso_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_ff <= SYNC_INIT;
      mode_ff <= MODE_RESET;
      ptr_ff <= PTR_RESET;
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
      int_n_ff <= 1'b1;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      maddr_ff <= 15'h0000;
      mwdata_ff <= 8'h00;
      mwe_ff <= 1'b0;
      mre_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      spi_pend_ff <= 1'b0;
      sh_ff <= 32'h00000000;
      cnt_ff <= 6'd0;
      mso_ff <= 8'h00;
      spi_rd_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= nxt_prev;
      mode_ff <= nxt_mode;
      ptr_ff <= nxt_ptr;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      int_n_ff <= nxt_int_n;
      miso_ff <= nxt_miso;
      miso_oe_ff <= nxt_miso_oe;
      maddr_ff <= nxt_maddr;
      mwdata_ff <= nxt_mwdata;
      mwe_ff <= nxt_mwe;
      mre_ff <= nxt_mre;
      rd_pend_ff <= nxt_rd_pend;
      spi_pend_ff <= nxt_spi_pend;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      mso_ff <= nxt_mso;
      spi_rd_ff <= nxt_spi_rd;
    end
  end

  // outputs straight from flops
  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign int_n = int_n_ff;
  assign miso_out = miso_ff;
  assign miso_oe = miso_oe_ff;
  assign mem_addr = maddr_ff;
  assign mem_wdata = mwdata_ff;
  assign mem_we = mwe_ff;
  assign mem_re = mre_ff;
endmodule

// [hpa_assertions.sv]
`timescale 1ns/1ns
// ----------
// port checker
// ----------
module hpa_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [hpa_pkg::ADDR_W-1:0] addr_pin,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic spi_en,
  input wire logic int_req,
  input wire logic int_n,
  input wire logic data_oe,
  input wire logic miso_oe,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [hpa_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [hpa_pkg::DATA_W-1:0] mem_wdata
);
  import hpa_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_we_pulse; mem_we |=> !mem_we; endproperty
  property p_re_pulse; mem_re |=> !mem_re; endproperty
  property p_int; $past(!rst) |-> int_n == !$past(int_req); endproperty
  property p_rd; $fell(rd_n) && !cs_n && !spi_en |-> ##[3:6] data_oe; endproperty
  property p_oe_off; cs_n [*7] |-> !data_oe; endproperty
  property p_ser_idle; !spi_en [*8] |-> !miso_oe; endproperty
  property p_release; addr_pin[13] [*6] |-> !miso_oe; endproperty
  property p_re_oe; mem_re && spi_en |-> miso_oe; endproperty
  property p_we_hold; mem_we |=> $stable(mem_addr) && $stable(mem_wdata); endproperty
  property p_par_re; mem_re && !spi_en |-> data_oe; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
  a_re_pulse: assert property (p_re_pulse) else $error("read pulse too long");
  a_int: assert property (p_int) else $error("interrupt pin wrong");
  a_rd: assert property (p_rd) else $error("no read answer");
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  a_ser_idle: assert property (p_ser_idle) else $error("miso driven in parallel");
  a_release: assert property (p_release) else $error("miso held after deselect");
  a_re_oe: assert property (p_re_oe) else $error("serial read without miso");
  a_we_hold: assert property (p_we_hold) else $error("write fields moved");
  a_par_re: assert property (p_par_re) else $error("read without bus drive");
  c_spi_we: cover property (mem_we && spi_en);
  c_miso: cover property (miso_oe);
  c_rd: cover property (data_oe);
endmodule
bind hpa_host_port hpa_checker u_chk (.clk_sys, .rst, .addr_pin, .cs_n, .rd_n, .spi_en,
  .int_req, .int_n, .data_oe, .miso_oe, .mem_we, .mem_re, .mem_addr, .mem_wdata);

// [hpa_host_model.sv]
`timescale 1ns/1ns
// ----------
// host side: parallel and serial master
// ----------
module hpa_host_model (
  input wire logic clk_sys,
  input wire logic [hpa_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  output logic [hpa_pkg::ADDR_W-1:0] addr_pin,
  output logic [hpa_pkg::DATA_W-1:0] data_in,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic spi_en
);
  import hpa_pkg::*;
  localparam int H = 8;
  logic [14:0] a;
  logic mq;
  logic m;
  // released miso floats, so show the inverse of its last driven level
  assign m = miso_oe ? miso_out : ~mq;
  assign addr_pin = spi_en ? {a[14:12], m, a[10:0]} : a;
  always @(posedge clk_sys) if (miso_oe) mq <= miso_out;
  initial begin
    a = 15'h0000; data_in = 8'h00; cs_n = 1; rd_n = 1; wr_n = 1; spi_en = 0; mq = 0;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task pwr(input logic [14:0] adr, input logic [7:0] d);
    a <= adr; data_in <= d; cs_n <= 0; cyc(2);
    wr_n <= 0; cyc(6); wr_n <= 1; cyc(6); cs_n <= 1; cyc(8);
  endtask
  task prd(input logic [14:0] adr, output logic [7:0] d);
    int k;
    a <= adr; data_in <= ~data_in; cs_n <= 0; cyc(2); rd_n <= 0;
    for (k = 0; k < 20 && data_oe !== 1'b1; k++) cyc(1);
    if (k == 20) testbench.time_out();
    cyc(2); d = data_out; rd_n <= 1; cyc(2); cs_n <= 1; cyc(8);
  endtask
  // select framing, idle-low clock, msb first
  task spi(input logic [31:0] f, input int n, output logic [7:0] r);
    int i;
    r = 8'h00; a <= 15'h2000; cyc(H); a[13] <= 0; cyc(H);
    for (i = 0; i < n; i++) begin
      a[12] <= f[31-i]; cyc(H); a[14] <= 1; r = {r[6:0], m}; cyc(H); a[14] <= 0;
    end
    cyc(H); a[13] <= 1; a[12] <= ~a[12]; cyc(2*H);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  import hpa_pkg::*;
  logic clk_sys, rst, int_req, cs_n, rd_n, wr_n, spi_en, data_oe, int_n;
  logic miso_out, miso_oe, mem_we, mem_re;
  logic [ADDR_W-1:0] addr_pin, mem_addr;
  logic [DATA_W-1:0] data_in, data_out, mem_wdata, mem_rdata, wd, r;
  logic [14:0] wa;
  int fails, comparisons, we_cnt, re_cnt, n, nr;
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  // memory stand-in: pattern keyed on the address
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  // sampled on the falling edge, clear of the launching rising edge
  always @(negedge clk_sys) begin
    if (mem_we === 1'b1) begin
      wa <= mem_addr; wd <= mem_wdata; we_cnt <= we_cnt + 1;
    end
    if (mem_re === 1'b1) re_cnt <= re_cnt + 1;
  end
  hpa_host_port dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .addr_pin(addr_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .int_n(int_n), .spi_en(spi_en), .miso_out(miso_out), .miso_oe(miso_oe),
    .int_req(int_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata));
  hpa_host_model host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe),
    .miso_out(miso_out), .miso_oe(miso_oe), .addr_pin(addr_pin), .data_in(data_in),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .spi_en(spi_en));
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task time_out();
    fails++;
    wrap_up();
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys);
    time_out();
  end
  initial begin
    rst = 1; int_req = 0; fails = 0; comparisons = 0; we_cnt = 0; re_cnt = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    host.cyc(8);
    host.pwr(15'h1234, 8'hC3);
    chk("dir_waddr", {1'b0, wa}, 16'h1234);
    chk("dir_wdata", {8'h00, wd}, 16'h00C3);
    host.prd(15'h0055, r);
    chk("dir_rdata", {8'h00, r}, 16'h000F);
    // indirect with auto-increment, upper pins low
    host.pwr(DIRECT_MODE_ADDR, 8'h03);
    host.pwr({13'h0, LOC_PTR_HI}, 8'h04);
    host.pwr({13'h0, LOC_PTR_LO}, 8'h01);
    host.prd({13'h0, LOC_PTR_HI}, r);
    chk("ptr_hi", {8'h00, r}, 16'h0004);
    host.prd({13'h0, LOC_MODE}, r);
    chk("mode", {8'h00, r}, 16'h0003);
    host.pwr({13'h0, LOC_DATA}, 8'hA5);
    chk("ind_waddr", {1'b0, wa}, 16'h0401);
    host.prd({13'h0, LOC_DATA}, r);
    chk("ind_rdata", {8'h00, r}, 16'h0058);
    host.prd({13'h0, LOC_PTR_LO}, r);
    chk("ptr_lo", {8'h00, r}, 16'h0003);
    // auto-increment off: pointer must hold across a window read
    host.pwr({13'h0, LOC_MODE}, 8'h01);
    host.prd({13'h0, LOC_DATA}, r);
    chk("ind_rdata_noai", {8'h00, r}, 16'h0059);
    host.prd({13'h0, LOC_PTR_LO}, r);
    chk("ptr_hold", {8'h00, r}, 16'h0003);
    // back to direct, mode control read at address zero
    host.pwr({13'h0, LOC_MODE}, 8'h02);
    host.prd(DIRECT_MODE_ADDR, r);
    chk("dir_mode", {8'h00, r}, 16'h0002);
    int_req <= 1;
    host.cyc(3);
    chk("int_n", {15'h0, int_n}, 16'h0000);
    int_req <= 0;
    host.cyc(3);
    chk("int_off", {15'h0, int_n}, 16'h0001);
    // serial frames, pins repurposed
    host.a <= 15'h2000;
    host.spi_en <= 1;
    host.cyc(8);
    host.spi({OP_WRITE, 16'h0123, 8'h77}, 32, r);
    chk("spi_waddr", {1'b0, wa}, 16'h0123);
    chk("spi_wdata", {8'h00, wd}, 16'h0077);
    host.spi({OP_READ, 16'h0042, 8'h00}, 32, r);
    chk("spi_rdata", {8'h00, r}, 16'h0018);
    n = we_cnt;
    nr = re_cnt;
    host.spi({8'hAA, 16'h0055, 8'h33}, 32, r);
    chk("bad_op", 16'(we_cnt), 16'(n));
    chk("bad_op_rd", 16'(re_cnt), 16'(nr));
    host.spi({OP_WRITE, 16'h0066, 8'h44}, 31, r);
    chk("short", 16'(we_cnt), 16'(n));
    wrap_up();
  end
endmodule
